// ===== acm_pkg.sv
// Package for the conversion-mode control block: register layout,
// mode codes, settling-delay table and timing counts.
// Assumes a 20 MHz system clock feeding every process of the block.
package acm_pkg;

  // Clock and delay timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int DELAY_UNIT_NS = 8000;
  // One delay unit rounds up to whole clock cycles.
  localparam int DELAY_UNIT_CYC =
    (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register width and reset value of the mode register.
  localparam int REG_W = 16;
  localparam logic [15:0] MODE_REG_RESET = 16'h0000;

  // Field positions inside the mode register.
  localparam int REF_EN_BIT = 15;
  localparam int DELAY_LSB = 8;
  localparam int MODE_LSB = 4;
  localparam int CLKSEL_LSB = 2;

  // Mask of the bits that software may change; the rest read as zero.
  localparam logic [15:0] MODE_REG_WMASK = 16'h877C;

  // Conversion mode codes.
  typedef enum logic [2:0] {
    ACM_MODE_CONT    = 3'h0,
    ACM_MODE_SINGLE  = 3'h1,
    ACM_MODE_STANDBY = 3'h2,
    ACM_MODE_PDOWN   = 3'h3
  } acm_mode_t;

  // Settling delay, in delay units, for each code of the delay field.
  localparam logic [7:0] DLY_CODE0 = 8'h00;
  localparam logic [7:0] DLY_CODE1 = 8'h01;
  localparam logic [7:0] DLY_CODE2 = 8'h04;
  localparam logic [7:0] DLY_CODE3 = 8'h19;
  localparam logic [7:0] DLY_CODE4 = 8'h32;
  localparam logic [7:0] DLY_CODE5 = 8'h7D;
  localparam logic [7:0] DLY_CODE6 = 8'h7D;
  localparam logic [7:0] DLY_CODE7 = 8'hFA;

  // Sequencer states, Gray coded along idle, settle, convert.
  typedef enum logic [1:0] {
    ACM_ST_IDLE   = 2'b00,
    ACM_ST_SETTLE = 2'b01,
    ACM_ST_CONV   = 2'b11,
    ACM_ST_PDOWN  = 2'b10
  } acm_state_t;

  // Number of input channels that the sequencer walks through.
  localparam int NUM_CHAN = 4;

endpackage : acm_pkg

// ===== acm_delay_if.sv
// Interface between the sequencer and its settling-delay timer.
// Assumes both ends sit on the same system clock.
interface acm_delay_if;
  logic start;
  logic [7:0] units;
  logic busy;
  logic done;

  modport ctrl (output start, output units, input busy, input done);
  modport timer (input start, input units, output busy, output done);
endinterface : acm_delay_if

// ===== acm_settle_timer.sv
// Settling-delay timer: counts a number of fixed-length delay units.
// Assumes start is a one-cycle pulse and units is valid with it.
module acm_settle_timer
  import acm_pkg::*;
#(
  parameter int UNIT_CYCLES = DELAY_UNIT_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the sequencer.
  acm_delay_if.timer dly
);

  // Refuse a unit length that the 16-bit prescaler cannot count.
  if (UNIT_CYCLES < 1 || UNIT_CYCLES > 65535) begin : g_bad_unit
    $error("UNIT_CYCLES out of range");
  end

  logic [15:0] preCnt_r;
  logic [7:0] unitCnt_r;
  logic busy_r;
  logic done_r;

  // Prescaler and unit counter; a zero count finishes on the next edge.
  always_ff @(posedge sys_clk) begin
    done_r <= 1'b0;
    if (!rst_n) begin
      preCnt_r <= 16'h0000;
      unitCnt_r <= 8'h00;
      busy_r <= 1'b0;
    end else if (dly.start) begin
      preCnt_r <= 16'h0000;
      unitCnt_r <= dly.units;
      busy_r <= (dly.units != 8'h00);
      done_r <= (dly.units == 8'h00);
    end else if (busy_r) begin
      if (preCnt_r == 16'(UNIT_CYCLES - 1)) begin
        preCnt_r <= 16'h0000;
        unitCnt_r <= unitCnt_r - 8'h01;
        if (unitCnt_r == 8'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1; // Pulse marks the end of the last unit.
        end
      end else begin
        preCnt_r <= preCnt_r + 16'h0001;
      end
    end
  end

  assign dly.busy = busy_r;
  assign dly.done = done_r;

endmodule : acm_settle_timer

// ===== acm_mode_ctrl.sv
// Conversion-mode control: mode register, channel sequencer, settling
// delay after each channel switch, standby and power-down handling.
// Assumes the serial interface decoder hands over whole 16-bit words
// for the mode register and pulses ifReset when it is reset.
module acm_mode_ctrl
  import acm_pkg::*;
#(
  parameter int UNIT_CYCLES = DELAY_UNIT_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial interface side.
  input wire logic ifReset,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData_r,
  // Converter side.
  input wire logic [3:0] chanEnable,
  input wire logic convDone,
  output logic [1:0] chanSel_r,
  output logic convRun_r,
  output logic settling_r,
  output logic filterReset_r,
  output logic dataReadyClear_r,
  output logic standby_r,
  output logic powerDown_r,
  output logic refEnable_r,
  output logic [1:0] clkSel_r
);

  // A zero-length unit would let the settle finish before it started.
  if (UNIT_CYCLES < 1) begin : g_bad_unit
    $error("UNIT_CYCLES must be at least one");
  end

  acm_delay_if dly ();

  acm_settle_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .dly(dly.timer)
  );

  acm_state_t state_r;
  logic [15:0] modeReg_r;
  logic dlyStart_r;
  logic [7:0] dlyUnits_r;
  logic wrHit;
  logic wrAccept;
  logic [2:0] wrMode;
  logic [2:0] curMode;
  logic [2:0] wrDelay;
  logic [7:0] wrUnits;
  logic [15:0] wrValue;
  logic [1:0] firstIdx;
  logic [1:0] nextIdx;
  logic nextWrap;
  logic anyEnabled;

  // Maps a delay code to a count of 8 us units.
  function automatic logic [7:0] delayUnits(input logic [2:0] code);
    logic [7:0] u;
    case (code)
      3'h0: u = DLY_CODE0;
      3'h1: u = DLY_CODE1;
      3'h2: u = DLY_CODE2;
      3'h3: u = DLY_CODE3;
      3'h4: u = DLY_CODE4;
      3'h5: u = DLY_CODE5;
      3'h6: u = DLY_CODE6;
      default: u = DLY_CODE7;
    endcase
    return u;
  endfunction : delayUnits

  // Lowest enabled channel starts every sequence.
  always_comb begin
    firstIdx = 2'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (chanEnable[i]) begin
        firstIdx = 2'(i);
      end
    end
  end

  // Next enabled channel after the current one, with its wrap flag.
  always_comb begin
    logic found;
    logic [1:0] cand;
    found = 1'b0;
    cand = 2'h0;
    nextIdx = chanSel_r;
    nextWrap = 1'b1;
    for (int k = 1; k <= NUM_CHAN; k++) begin
      cand = chanSel_r + 2'(k);
      if (!found && chanEnable[cand]) begin
        found = 1'b1;
        nextIdx = cand;
        nextWrap = (cand <= chanSel_r);
      end
    end
  end

  assign anyEnabled = (chanEnable != 4'h0);
  assign curMode = modeReg_r[MODE_LSB +: 3];
  assign wrMode = regWrData[MODE_LSB +: 3];
  assign wrDelay = regWrData[DELAY_LSB +: 3];
  assign wrUnits = delayUnits(wrDelay);
  // Writes while powered down are ignored; only ifReset or rst_n wakes us.
  assign wrHit = regWrEn && (state_r != ACM_ST_PDOWN);
  // Power-down needs standby as the mode held just before.
  assign wrAccept = !(wrMode == ACM_MODE_PDOWN &&
                      curMode != ACM_MODE_STANDBY);
  // A refused power-down still stores the other fields.
  always_comb begin
    wrValue = regWrData & MODE_REG_WMASK;
    if (!wrAccept) begin
      wrValue[MODE_LSB +: 3] = curMode;
    end
  end

  // Mode register; interface reset restores every default.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ifReset) begin
      modeReg_r <= MODE_REG_RESET;
    end else if (wrHit) begin
      modeReg_r <= wrValue;
    end else if (state_r == ACM_ST_CONV && convDone &&
                 curMode == ACM_MODE_SINGLE && nextWrap) begin
      modeReg_r[MODE_LSB +: 3] <= ACM_MODE_STANDBY;
    end
  end

  // Sequencer: channel choice, settling and conversion.
  always_ff @(posedge sys_clk) begin
    dlyStart_r <= 1'b0;
    if (!rst_n || ifReset) begin
      state_r <= ACM_ST_IDLE;
      chanSel_r <= 2'h0;
      dlyUnits_r <= 8'h00;
    end else if (wrHit) begin
      // An accepted continuous or single write with a channel enabled restarts conversion from the first channel.
      dlyUnits_r <= wrUnits;
      if (!wrAccept) begin
        state_r <= state_r;
      end else if (wrMode == ACM_MODE_PDOWN) begin
        state_r <= ACM_ST_PDOWN;
      end else if ((wrMode == ACM_MODE_CONT ||
                    wrMode == ACM_MODE_SINGLE) && anyEnabled) begin
        chanSel_r <= firstIdx;
        state_r <= ACM_ST_SETTLE;
        dlyStart_r <= 1'b1;
      end else begin
        state_r <= ACM_ST_IDLE;
      end
    end else begin
      case (state_r)
        ACM_ST_SETTLE: begin
          if (dly.done) begin
            state_r <= ACM_ST_CONV;
          end
        end
        ACM_ST_CONV: begin
          if (convDone) begin
            if (curMode == ACM_MODE_SINGLE && nextWrap) begin
              state_r <= ACM_ST_IDLE;
            end else if (nextIdx != chanSel_r) begin
              chanSel_r <= nextIdx;
              state_r <= ACM_ST_SETTLE;
              dlyStart_r <= 1'b1;
            end else begin
              state_r <= ACM_ST_CONV;
            end
          end
        end
        ACM_ST_PDOWN: begin
          state_r <= ACM_ST_PDOWN;
        end
        default: begin
          state_r <= ACM_ST_IDLE;
        end
      endcase
    end
  end

  assign dly.start = dlyStart_r;
  assign dly.units = dlyUnits_r;

  // Write side effects toward the filter and data-ready flag.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ifReset) begin
      filterReset_r <= 1'b0;
      dataReadyClear_r <= 1'b0;
    end else begin
      filterReset_r <= wrHit;
      dataReadyClear_r <= wrHit;
    end
  end

  // Status outputs follow the state and mode register one edge later, all registered.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ifReset) begin
      convRun_r <= 1'b0;
      settling_r <= 1'b0;
      standby_r <= 1'b0;
      powerDown_r <= 1'b0;
      refEnable_r <= 1'b0;
      clkSel_r <= 2'h0;
      regRdData_r <= MODE_REG_RESET;
    end else begin
      convRun_r <= (state_r == ACM_ST_CONV);
      settling_r <= (state_r == ACM_ST_SETTLE);
      standby_r <= (state_r == ACM_ST_IDLE);
      powerDown_r <= (state_r == ACM_ST_PDOWN);
      refEnable_r <= modeReg_r[REF_EN_BIT] && (state_r != ACM_ST_PDOWN);
      clkSel_r <= modeReg_r[CLKSEL_LSB +: 2];
      regRdData_r <= modeReg_r;
    end
  end

endmodule : acm_mode_ctrl

// ===== acm_mode_ctrl_props.sv
// Checker for the conversion-mode control block, bound to its top.
// Assumes one clock; rst_n and ifReset both reset the block.
module acm_mode_ctrl_props
  import acm_pkg::*;
#(
  parameter int UNIT_CYCLES = DELAY_UNIT_CYC
) (
  // Clock and resets.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ifReset,
  // Watched ports.
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData_r,
  input wire logic [3:0] chanEnable,
  input wire logic convDone,
  input wire logic [1:0] chanSel_r,
  input wire logic convRun_r,
  input wire logic settling_r,
  input wire logic filterReset_r,
  input wire logic standby_r,
  input wire logic powerDown_r,
  input wire logic refEnable_r
);
  localparam int UNITS [8] = '{0, 1, 4, 25, 50, 125, 125, 250};
  int cnt_r;
  int lim;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || ifReset);
  // Length of the running settle; a write restarts the count.
  always_ff @(posedge sys_clk) begin
    cnt_r <= (settling_r && !filterReset_r) ? cnt_r + 1 : 0;
  end
  assign lim = UNITS[regRdData_r[10:8]] * UNIT_CYCLES;
  a_write_restarts: assert property (
    regWrEn && !powerDown_r && !$past(regWrEn && regWrData[6:4] == 3'h3)
    |=> filterReset_r) else $error("no restart");
  a_pdown_deaf: assert property (
    powerDown_r && regWrEn |=> !filterReset_r) else $error("pdown write");
  a_pdown_quiet: assert property (
    powerDown_r |-> !refEnable_r && !convRun_r && !settling_r)
    else $error("active in pdown");
  a_pdown_refused: assert property (
    regWrEn && regWrData[6:4] == 3'h3 && regRdData_r[6:4] != 3'h2 &&
    !$past(regWrEn) && !$past(regWrEn, 2) && !powerDown_r &&
    !$past(convDone)
    |=> !powerDown_r [*3]) else $error("pdown not from standby");
  a_settle_len: assert property (
    $fell(settling_r) && !$past(filterReset_r)
    |-> cnt_r >= lim && cnt_r <= lim + 3) else $error("settle length");
  a_settle_first: assert property (
    $rose(convRun_r) |-> $past(settling_r) || $past(settling_r, 2))
    else $error("conversion without settle");
  a_chan_advance: assert property (
    convDone && convRun_r && !$past(convDone) && !regWrEn &&
    !$past(regWrEn) &&
    regRdData_r[6:4] == 3'h0 && $countones(chanEnable) > 1
    |=> chanSel_r != $past(chanSel_r) && chanEnable[chanSel_r])
    else $error("channel not advanced");
  a_standby_hold: assert property (
    regRdData_r[6:4] == 3'h2 && !$past(regWrEn) |-> standby_r)
    else $error("standby not held");
  c_pdown: cover property ($rose(powerDown_r));
  c_long_settle: cover property ($fell(settling_r) && lim > 900);
  c_single_end: cover property ($rose(standby_r) && !regWrEn);
endmodule : acm_mode_ctrl_props

bind acm_mode_ctrl acm_mode_ctrl_props #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .ifReset(ifReset), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdData_r(regRdData_r),
  .chanEnable(chanEnable), .convDone(convDone), .chanSel_r(chanSel_r),
  .convRun_r(convRun_r), .settling_r(settling_r),
  .filterReset_r(filterReset_r), .standby_r(standby_r),
  .powerDown_r(powerDown_r), .refEnable_r(refEnable_r));

// ===== acm_host_model.sv
// Host model driving the mode register port and the interface reset.
// Assumes the bench owns the clock and calls these tasks in turn.
module acm_host_model (
  // Clock.
  input wire logic sys_clk,
  // Register port.
  output logic regWrEn,
  output logic [15:0] regWrData,
  output logic ifReset
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle port at time zero.
  initial begin
    regWrEn = 1'b0;
    regWrData = 16'h0000;
    ifReset = 1'b0;
  end
  // One whole word per write; reserved modes are never sent.
  // No dual mains rejection exists here, so delays are trusted.
  task automatic wr(input logic [15:0] d);
    @(posedge sys_clk);
    #5;
    regWrEn = 1'b1;
    regWrData = d;
    @(posedge sys_clk);
    #5;
    regWrEn = 1'b0;
    regWrData = ~d;
  endtask : wr
  // Standby always goes first, else the device refuses.
  task automatic pdown();
    wr(16'h0020);
    wr(16'h0030);
  endtask : pdown
  // Only an interface reset or rst_n leaves power-down.
  task automatic wake();
    @(posedge sys_clk);
    #5;
    ifReset = 1'b1;
    @(posedge sys_clk);
    #5;
    ifReset = 1'b0;
  endtask : wake
endmodule : acm_host_model

// ===== tb_adc_conversion_mode_control.sv
// Self-checking bench for the conversion-mode control block.
// Assumes a short delay unit so the longest settle stays brief.
module tb_adc_conversion_mode_control;
  import acm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UC = 4;
  logic sys_clk, rst_n, ifReset, regWrEn, convDone;
  logic [15:0] regWrData, regRdData_r, d;
  logic [3:0] chanEnable;
  logic [1:0] chanSel_r, clkSel_r, c;
  logic convRun_r, settling_r, filterReset_r, dataReadyClear_r;
  logic standby_r, powerDown_r, refEnable_r;
  int mismatches, compares, seed, n, u;
  acm_host_model h (.sys_clk(sys_clk), .regWrEn(regWrEn),
    .regWrData(regWrData), .ifReset(ifReset));
  acm_mode_ctrl #(.UNIT_CYCLES(UC)) u_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .ifReset(ifReset), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdData_r(regRdData_r),
    .chanEnable(chanEnable), .convDone(convDone), .chanSel_r(chanSel_r),
    .convRun_r(convRun_r), .settling_r(settling_r),
    .filterReset_r(filterReset_r), .dataReadyClear_r(dataReadyClear_r),
    .standby_r(standby_r), .powerDown_r(powerDown_r),
    .refEnable_r(refEnable_r), .clkSel_r(clkSel_r));
  // Settle length in delay units for each delay code.
  function automatic int units(input logic [2:0] k);
    int t [8] = '{0, 1, 4, 25, 50, 125, 125, 250};
    return t[k];
  endfunction : units
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #5;
  endtask : tick
  // Waits for a conversion, then reports it finished.
  task automatic finish_conv();
    tick(2);
    n = 0;
    while (convRun_r !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    convDone = 1'b1;
    tick(1);
    convDone = 1'b0;
  endtask : finish_conv
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // Free-running clock.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // The run is about 5000 cycles; give it over three times that.
  initial begin
    #1000000;
    mismatches++;
    close_out();
  end
  // Main sequence.
  initial begin
    seed = 32'h7b1c;
    mismatches = 0;
    compares = 0;
    rst_n = 1'b0;
    convDone = 1'b0;
    chanEnable = 4'h0;
    tick(6);
    rst_n = 1'b1;
    tick(2);
    chk(regRdData_r, 16'h0000);
    chk({15'h0, standby_r}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed));
      d[6:4] = 3'h2;
      h.wr(d);
      // The write pulses stand only in the cycle right after the strobe.
      chk({15'h0, filterReset_r}, 16'h0001);
      chk({15'h0, dataReadyClear_r}, 16'h0001);
      tick(1);
      chk(regRdData_r, d & 16'h877C);
      chk({14'h0, clkSel_r}, {14'h0, d[3:2]});
      chk({15'h0, refEnable_r}, {15'h0, d[15]});
    end
    $display("done: writes");
    // Every delay code, two channels so each conversion switches.
    chanEnable = 4'h3;
    for (int k = 0; k < 8; k++) begin
      h.wr({5'h00, k[2:0], 8'h00});
      // Take the channel before the conversion ends and switches it.
      c = chanSel_r;
      finish_conv();
      u = units(k[2:0]) * UC;
      n = 0;
      while (settling_r !== 1'b1 && n < 10) begin
        tick(1);
        n++;
      end
      n = 0;
      while (settling_r === 1'b1 && n < 1100) begin
        tick(1);
        n++;
      end
      chk({15'h0, n >= u && n <= u + 3}, 16'h0001);
      chk({15'h0, convRun_r}, 16'h0001);
      chk({14'h0, chanSel_r}, {14'h0, c ^ 2'h1});
    end
    $display("done: delays");
    h.wr(16'h0030);
    tick(3);
    chk({15'h0, powerDown_r}, 16'h0000);
    chk(regRdData_r, 16'h0000);
    chanEnable = 4'h5;
    h.wr(16'h0010);
    finish_conv();
    finish_conv();
    tick(4);
    chk({13'h0, regRdData_r[6:4]}, 16'h0002);
    chk({15'h0, standby_r}, 16'h0001);
    chk({15'h0, convRun_r}, 16'h0000);
    $display("done: single");
    h.pdown();
    tick(3);
    chk({15'h0, powerDown_r}, 16'h0001);
    h.wr(16'h8000);
    tick(2);
    chk({15'h0, refEnable_r}, 16'h0000);
    h.wake();
    tick(2);
    chk(regRdData_r, 16'h0000);
    chk({15'h0, powerDown_r}, 16'h0000);
    $display("done: power-down");
    close_out();
  end
endmodule : tb_adc_conversion_mode_control
